/* File: inc/ccr_map.svh */
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH

// command codes
`define CCR_CMD_PWM_CTRL      8'h04
`define CCR_CMD_ADC_GAP       8'h05
`define CCR_CMD_MISC_CTRL     8'h06

// pwm control word, only the rectifier follow bit lives here
`define CCR_PWM_FOLLOW_BIT    0

// channel gap field
`define CCR_GAP_MSB           6
`define CCR_GAP_LSB           0

// misc control word fields
`define CCR_MISC_RSVD_HI_BIT  15
`define CCR_MISC_CHOP_BIT     14
`define CCR_MISC_PSCALE_BIT   13
`define CCR_MISC_DCLOOP_BIT   12
`define CCR_MISC_TSLOPE_BIT   11
`define CCR_MISC_RSVD_MSB     10
`define CCR_MISC_RSVD_LSB     9
`define CCR_MISC_ADDRKEEP_BIT 8
`define CCR_MISC_FILT_MSB     7
`define CCR_MISC_FILT_LSB     4
`define CCR_MISC_VINWAIT_BIT  3
`define CCR_MISC_PGREF_BIT    2
`define CCR_MISC_DLYCLK_BIT   1
`define CCR_MISC_TONHOLD_BIT  0

// reset values
`define CCR_PWM_CTRL_RST      1'h0
`define CCR_ADC_GAP_RST       7'h00
`define CCR_MISC_CTRL_RST     16'h0000

// address strap sampling
`define CCR_STRAP_ARM_ADDR    8'h20
`define CCR_STRAP_SAMPLES     3'h7

// timing
`define CCR_CLK_PERIOD_NS     5
`define CCR_GAP_LSB_NS        100
`define CCR_FILT_LSB_NS       10
`define CCR_GAP_LSB_CYCLES    (`CCR_GAP_LSB_NS / `CCR_CLK_PERIOD_NS)
`define CCR_FILT_LSB_CYCLES   (`CCR_FILT_LSB_NS / `CCR_CLK_PERIOD_NS)
`define CCR_DLY_SLOW_NS       50000
`define CCR_DLY_FAST_NS       20000
`define CCR_DLY_SLOW_CYCLES   (`CCR_DLY_SLOW_NS / `CCR_CLK_PERIOD_NS)
`define CCR_DLY_FAST_CYCLES   (`CCR_DLY_FAST_NS / `CCR_CLK_PERIOD_NS)

`endif

/* File: inc/ccr_pkg.sv */
package ccr_pkg;
	typedef enum logic [0:0] {
		CCR_GAP_IDLE,
		CCR_GAP_WAIT
	} ccr_gap_state_t;
endpackage

/* File: rtl/ccr_glitch_filter.sv */
`timescale 1ns/1ps
module ccr_glitch_filter #(
	parameter int LEN_W = 5
) (
	input  wire logic             ref_clk,
	input  wire logic             nrst,
	input  wire logic             din,
	input  wire logic [LEN_W-1:0] len_cycles,
	output logic                  dout
);
	logic [LEN_W-1:0] run;

	generate
		if (LEN_W < 1) begin : g_chk
			$error("ccr_glitch_filter: LEN_W must be at least 1");
		end
	endgenerate

	// output follows only after the input has differed for len_cycles + 1 cycles
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			run  <= '0;
			dout <= 1'b1;
		end else if (din == dout) begin
			run <= '0;
		end else if (run >= len_cycles) begin
			run  <= '0;
			dout <= din;
		end else begin
			run <= run + 1'b1;
		end
	end
endmodule

/* File: rtl/ccr_config_regs.sv */
`timescale 1ns/1ps
`include "ccr_map.svh"
module ccr_config_regs
	import ccr_pkg::*;
#(
	parameter int PWR_W           = 16,
	parameter int VIN_W           = 16,
	parameter int VOUT_W          = 16,
	parameter int DLY_SLOW_CYCLES = `CCR_DLY_SLOW_CYCLES,
	parameter int DLY_FAST_CYCLES = `CCR_DLY_FAST_CYCLES
) (
	input  wire logic              ref_clk,
	input  wire logic              nrst,
	input  wire logic [7:0]        reg_cmd,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic [15:0]       reg_wdata,
	output logic [15:0]            reg_rdata,
	output logic                   reg_rvalid,
	output logic                   reg_hit,
	input  wire logic              primary_gate_out,
	input  wire logic              soft_start_active,
	input  wire logic              pwm_adj_normal_bit,
	input  wire logic              other_adjust_active,
	output logic                   rectifier_gate_out,
	input  wire logic              adc_conv_done,
	output logic                   adc_start_next,
	output logic                   bandgap_chop_enable,
	input  wire logic [PWR_W-1:0]  measured_output_power,
	output logic [9:0]             power_indicator_output,
	output logic                   dc_loop_enable,
	output logic                   die_temp_slope_sel,
	input  wire logic [7:0]        stored_address,
	input  wire logic              strap_sample_done,
	output logic                   strap_sample_req,
	input  wire logic              scl_pin,
	input  wire logic              sda_pin,
	output logic                   scl_filtered,
	output logic                   sda_filtered,
	input  wire logic [VIN_W-1:0]  measured_input_voltage,
	input  wire logic [VIN_W-1:0]  input_turn_on_threshold,
	output logic                   start_permit,
	output logic                   power_good_ref_sel,
	output logic                   delay_count_tick,
	input  wire logic [VOUT_W-1:0] measured_output_voltage,
	input  wire logic [VOUT_W-1:0] output_undervoltage_min_level,
	output logic                   hold_min_ontime
);
	localparam int GAP_CNT_W = 12;
	localparam int FILT_W    = 5;
	localparam int DLY_W     = 16;
	localparam logic [GAP_CNT_W-1:0] GAP_STEP = GAP_CNT_W'(`CCR_GAP_LSB_CYCLES);
	localparam logic [FILT_W-1:0]    FILT_STEP = FILT_W'(`CCR_FILT_LSB_CYCLES);

	generate
		if (PWR_W < 11) begin : g_chk_pwr
			$error("ccr_config_regs: PWR_W must be at least 11");
		end
		if (DLY_SLOW_CYCLES < 1 || DLY_FAST_CYCLES < 1 ||
			DLY_SLOW_CYCLES > 65535 || DLY_FAST_CYCLES > 65535) begin : g_chk_dly
			$error("ccr_config_regs: delay tick counts out of range");
		end
		if (VIN_W < 1 || VOUT_W < 1) begin : g_chk_vw
			$error("ccr_config_regs: VIN_W and VOUT_W must be at least 1");
		end
		// longest gap and filter spans must fit their counters
		if (127 * `CCR_GAP_LSB_CYCLES >= (1 << GAP_CNT_W)) begin : g_chk_gap
			$error("ccr_config_regs: gap counter too narrow");
		end
		if (15 * `CCR_FILT_LSB_CYCLES >= (1 << FILT_W)) begin : g_chk_filt
			$error("ccr_config_regs: filter counter too narrow");
		end
	endgenerate

	logic                 rect_follow_enable;
	logic [6:0]           adc_gap;
	logic [15:0]          misc_ctrl;
	logic [15:0]          next_rdata;
	logic                 cmd_known;
	ccr_gap_state_t       gap_state;
	logic [GAP_CNT_W-1:0] gap_cnt;
	logic [GAP_CNT_W-1:0] gap_target;
	logic                 addr_at_arm;
	logic                 addr_at_arm_d;
	logic [2:0]           strap_left;
	logic                 scl_s1;
	logic                 scl_s2;
	logic                 sda_s1;
	logic                 sda_s2;
	logic [FILT_W-1:0]    filt_len;
	logic [DLY_W-1:0]     dly_cnt;
	logic [DLY_W-1:0]     dly_last;

	always_comb begin
		cmd_known  = 1'b1;
		next_rdata = 16'h0000;
		case (reg_cmd)
			`CCR_CMD_PWM_CTRL:  next_rdata[`CCR_PWM_FOLLOW_BIT] = rect_follow_enable;
			`CCR_CMD_ADC_GAP:   next_rdata[`CCR_GAP_MSB:`CCR_GAP_LSB] = adc_gap;
			`CCR_CMD_MISC_CTRL: next_rdata = misc_ctrl;
			default:            cmd_known = 1'b0;
		endcase
	end

	assign reg_hit = cmd_known;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rect_follow_enable <= `CCR_PWM_CTRL_RST;
			adc_gap            <= `CCR_ADC_GAP_RST;
			misc_ctrl          <= `CCR_MISC_CTRL_RST;
		end else if (reg_wr) begin
			case (reg_cmd)
				`CCR_CMD_PWM_CTRL:  rect_follow_enable <= reg_wdata[`CCR_PWM_FOLLOW_BIT];
				`CCR_CMD_ADC_GAP:   adc_gap <= reg_wdata[`CCR_GAP_MSB:`CCR_GAP_LSB];
				// reserved bits are stored like the rest and drive nothing
				`CCR_CMD_MISC_CTRL: misc_ctrl <= reg_wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata  <= 16'h0000;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= next_rdata;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rectifier_gate_out <= 1'b0;
		end else if (rect_follow_enable && !soft_start_active &&
			!pwm_adj_normal_bit && !other_adjust_active) begin
			rectifier_gate_out <= primary_gate_out;
		end else begin
			rectifier_gate_out <= 1'b0;
		end
	end

	assign gap_target = GAP_CNT_W'(adc_gap) * GAP_STEP;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			gap_state      <= CCR_GAP_IDLE;
			gap_cnt        <= '0;
			adc_start_next <= 1'b0;
		end else begin
			adc_start_next <= 1'b0;
			case (gap_state)
				CCR_GAP_IDLE: begin
					gap_cnt <= '0;
					if (adc_conv_done) begin
						if (gap_target == '0) begin
							adc_start_next <= 1'b1;
						end else begin
							gap_state <= CCR_GAP_WAIT;
						end
					end
				end
				CCR_GAP_WAIT: begin
					if (gap_cnt + 1'b1 >= gap_target) begin
						adc_start_next <= 1'b1;
						gap_state      <= CCR_GAP_IDLE;
						gap_cnt        <= '0;
					end else begin
						gap_cnt <= gap_cnt + 1'b1;
					end
				end
				default: gap_state <= CCR_GAP_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			bandgap_chop_enable    <= 1'b0;
			dc_loop_enable         <= 1'b0;
			die_temp_slope_sel     <= 1'b0;
			power_good_ref_sel     <= 1'b0;
			power_indicator_output <= 10'h000;
		end else begin
			bandgap_chop_enable <= misc_ctrl[`CCR_MISC_CHOP_BIT];
			dc_loop_enable      <= misc_ctrl[`CCR_MISC_DCLOOP_BIT];
			die_temp_slope_sel  <= misc_ctrl[`CCR_MISC_TSLOPE_BIT];
			power_good_ref_sel  <= misc_ctrl[`CCR_MISC_PGREF_BIT];
			if (misc_ctrl[`CCR_MISC_PSCALE_BIT]) begin
				power_indicator_output <= measured_output_power[10:1];
			end else begin
				power_indicator_output <= measured_output_power[9:0];
			end
		end
	end

	assign addr_at_arm = (stored_address == `CCR_STRAP_ARM_ADDR);

	// one-shot burst armed on the address reaching the arm value
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			addr_at_arm_d <= 1'b0;
			strap_left    <= 3'h0;
		end else begin
			addr_at_arm_d <= addr_at_arm;
			if (addr_at_arm && !addr_at_arm_d) begin
				strap_left <= `CCR_STRAP_SAMPLES;
			end else if (strap_sample_done && strap_left != 3'h0) begin
				strap_left <= strap_left - 3'h1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			strap_sample_req <= 1'b0;
		end else begin
			strap_sample_req <= misc_ctrl[`CCR_MISC_ADDRKEEP_BIT] ||
				(strap_left != 3'h0 && !(strap_sample_done && strap_left == 3'h1));
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
		end else begin
			scl_s1 <= scl_pin;
			scl_s2 <= scl_s1;
			sda_s1 <= sda_pin;
			sda_s2 <= sda_s1;
		end
	end

	assign filt_len = FILT_W'(misc_ctrl[`CCR_MISC_FILT_MSB:`CCR_MISC_FILT_LSB]) * FILT_STEP;

	ccr_glitch_filter #(
		.LEN_W (FILT_W)
	) u_scl_filter (
		.ref_clk    (ref_clk),
		.nrst       (nrst),
		.din        (scl_s2),
		.len_cycles (filt_len),
		.dout       (scl_filtered)
	);

	ccr_glitch_filter #(
		.LEN_W (FILT_W)
	) u_sda_filter (
		.ref_clk    (ref_clk),
		.nrst       (nrst),
		.din        (sda_s2),
		.len_cycles (filt_len),
		.dout       (sda_filtered)
	);

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			start_permit    <= 1'b0;
			hold_min_ontime <= 1'b0;
		end else begin
			start_permit <= !misc_ctrl[`CCR_MISC_VINWAIT_BIT] ||
				(measured_input_voltage > input_turn_on_threshold);
			hold_min_ontime <= misc_ctrl[`CCR_MISC_TONHOLD_BIT] && soft_start_active &&
				!(measured_output_voltage > output_undervoltage_min_level);
		end
	end

	assign dly_last = misc_ctrl[`CCR_MISC_DLYCLK_BIT] ?
		DLY_W'(DLY_SLOW_CYCLES - 1) : DLY_W'(DLY_FAST_CYCLES - 1);

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			dly_cnt          <= '0;
			delay_count_tick <= 1'b0;
		end else if (dly_cnt >= dly_last) begin
			dly_cnt          <= '0;
			delay_count_tick <= 1'b1;
		end else begin
			dly_cnt          <= dly_cnt + 1'b1;
			delay_count_tick <= 1'b0;
		end
	end
endmodule

/* File: sim/ccr_config_regs_assertions.sv */
`timescale 1ns/1ps
module ccr_chk (
	input wire logic        ref_clk,
	input wire logic        nrst,
	input wire logic [7:0]  reg_cmd,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic        reg_hit,
	input wire logic        primary_gate_out,
	input wire logic        soft_start_active,
	input wire logic        pwm_adj_normal_bit,
	input wire logic        other_adjust_active,
	input wire logic        rectifier_gate_out,
	input wire logic        bandgap_chop_enable,
	input wire logic        dc_loop_enable,
	input wire logic        die_temp_slope_sel,
	input wire logic        hold_min_ontime
);
	logic [15:0] sh;
	logic        sp;

	// shadow copies of the written control words
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sh <= 16'h0000;
			sp <= 1'b0;
		end else begin
			if (reg_wr && reg_cmd == 8'h06)
				sh <= reg_wdata;
			if (reg_wr && reg_cmd == 8'h04)
				sp <= reg_wdata[0];
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	a_rect_follow_gate:
	assert property (rectifier_gate_out == ($past(sp) && $past(primary_gate_out) &&
		!$past(soft_start_active | pwm_adj_normal_bit | other_adjust_active)))
		else $error("rectifier gate mismatch");
	a_pwm_read_back:
	assert property (reg_rd && reg_cmd == 8'h04 |=> reg_rdata == {15'h0000, $past(sp)})
		else $error("pwm control readback mismatch");
	a_misc_read_back:
	assert property (reg_rd && reg_cmd == 8'h06 |=> reg_rdata == $past(sh))
		else $error("misc readback mismatch");
	a_gap_top_zero:
	assert property (reg_rd && reg_cmd == 8'h05 |=> reg_rdata[15:7] == 9'h000)
		else $error("gap upper bits set");
	a_chop_follow:
	assert property (bandgap_chop_enable == $past(sh[14])) else $error("chop mismatch");
	a_dc_loop:
	assert property (dc_loop_enable == $past(sh[12])) else $error("dc loop mismatch");
	a_slope_sel:
	assert property (die_temp_slope_sel == $past(sh[11])) else $error("slope mismatch");
	a_chop_write:
	assert property (reg_wr && reg_cmd == 8'h06 |->
		##2 bandgap_chop_enable == $past(reg_wdata[14], 2))
		else $error("chop late after write");
	a_hit_decode:
	assert property (reg_hit == (reg_cmd == 8'h04 || reg_cmd == 8'h05 || reg_cmd == 8'h06))
		else $error("command decode mismatch");
	a_hold_in_ss:
	assert property (hold_min_ontime |-> $past(soft_start_active))
		else $error("on-time hold outside soft start");
endmodule

bind ccr_config_regs ccr_chk ccr_chk_i (.*);

/* File: sim/ccr_host.sv */
`timescale 1ns/1ps
module ccr_host (
	input  wire logic        ref_clk,
	input  wire logic [15:0] reg_rdata,
	input  wire logic        reg_rvalid,
	output logic [7:0]       reg_cmd,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic [15:0]      reg_wdata
);
	initial begin
		{reg_wr, reg_rd} = 2'h0;
		{reg_cmd, reg_wdata} = 24'hff0000;
	end

	// one-cycle strobe; released lines show the inverse
	task automatic wr(input logic [7:0] c, input logic [15:0] v);
		@(posedge ref_clk);
		#1;
		reg_cmd = c;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(posedge ref_clk);
		#1;
		reg_wr = 1'b0;
		reg_cmd = ~c;
		reg_wdata = ~v;
	endtask

	task automatic rd(input logic [7:0] c, output logic [15:0] v, output logic ok);
		@(posedge ref_clk);
		#1;
		reg_cmd = c;
		reg_rd = 1'b1;
		@(posedge ref_clk);
		#1;
		reg_rd = 1'b0;
		reg_cmd = ~c;
		ok = reg_rvalid;
		v = reg_rdata;
	endtask
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	localparam int SLOW = 20;
	localparam int FAST = 8;
	logic        ref_clk = 1'b0, nrst = 1'b0, reg_wr, reg_rd, reg_rvalid, reg_hit, ok, e;
	logic        primary_gate_out, soft_start_active, pwm_adj_normal_bit, other_adjust_active;
	logic        rectifier_gate_out, adc_conv_done, adc_start_next, bandgap_chop_enable;
	logic        dc_loop_enable, die_temp_slope_sel, strap_sample_done, strap_sample_req;
	logic        scl_pin, sda_pin, scl_filtered, sda_filtered, start_permit, hold_min_ontime;
	logic        power_good_ref_sel, delay_count_tick;
	logic [3:0]  r;
	logic [7:0]  reg_cmd, stored_address;
	logic [9:0]  power_indicator_output;
	logic [15:0] reg_wdata, reg_rdata, measured_output_power, measured_input_voltage, w, d;
	logic [15:0] input_turn_on_threshold, measured_output_voltage, output_undervoltage_min_level;
	int          error_cnt = 0, total_checks = 0, k, n, g;

	ccr_config_regs #(.DLY_SLOW_CYCLES(SLOW), .DLY_FAST_CYCLES(FAST)) ccr_config_regs_i (.*);
	ccr_host ccr_host_i (.*);

	always #2.5 ref_clk = ~ref_clk;

	function automatic int gap_cyc(input int v);
		return v * 100 / 5;
	endfunction
	function automatic int filt_cyc(input int v);
		return 3 + v * 10 / 5;
	endfunction
	function automatic logic [15:0] pind(input logic s, input logic [15:0] p);
		return 16'(s ? p[10:1] : p[9:0]);
	endfunction
	task automatic conclude;
		if (error_cnt == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge ref_clk);
		#1;
	endtask
	task automatic lim(input int c);
		if (c >= 3000) begin
			error_cnt++;
			conclude();
		end
	endtask
	task automatic rd(input logic [7:0] c, input logic [15:0] x, input string nm);
		ccr_host_i.rd(c, d, ok);
		lim(ok === 1'b1 ? 0 : 3000);
		chk(nm, d, x);
	endtask

	initial begin
		{primary_gate_out, soft_start_active, pwm_adj_normal_bit, other_adjust_active} = 4'h0;
		{adc_conv_done, strap_sample_done, scl_pin, sda_pin} = 4'h3;
		{stored_address, measured_output_power} = 24'h000000;
		{measured_input_voltage, measured_output_voltage} = 32'h00000000;
		{input_turn_on_threshold, output_undervoltage_min_level} = 32'h01000100;
		k = $urandom(77);
		tick(2);
		nrst = 1'b1;
		rd(8'h05, 16'h0000, "gap_rst");
		chk("start_free", 16'(start_permit), 16'h0001);
		for (k = 0; k < 6; k++) begin
			w = (k == 0) ? 16'hffff : 16'($urandom());
			measured_output_power = 16'($urandom());
			ccr_host_i.wr(8'h06, w);
			tick(2);
			chk("chop", 16'(bandgap_chop_enable), 16'(w[14]));
			chk("dc_loop", 16'(dc_loop_enable), 16'(w[12]));
			chk("slope", 16'(die_temp_slope_sel), 16'(w[11]));
			chk("pg_ref", 16'(power_good_ref_sel), 16'(w[2]));
			chk("pwr_ind", 16'(power_indicator_output), pind(w[13], measured_output_power));
			rd(8'h06, w, "misc_rd");
		end
		ccr_host_i.wr(8'h05, 16'hffff);
		rd(8'h05, 16'h007f, "gap_ro");
		for (k = 0; k < 3; k++) begin
			g = (k == 0) ? 127 : (k == 1) ? 0 : $urandom_range(1, 4);
			ccr_host_i.wr(8'h05, 16'(g));
			adc_conv_done = 1'b1;
			tick(1);
			adc_conv_done = 1'b0;
			for (n = 0; n < 3000 && adc_start_next !== 1'b1; n++)
				tick(1);
			lim(n);
			chk("gap", 16'(n), 16'(gap_cyc(g)));
		end
		ccr_host_i.wr(8'h04, 16'hffff);
		rd(8'h04, 16'h0001, "pwm_rd");
		for (k = 0; k < 80; k++) begin
			if (k % 40 == 0)
				ccr_host_i.wr(8'h04, (k == 0) ? 16'h0001 : 16'h0000);
			r = 4'($urandom()) & ((k % 2) ? 4'hf : 4'h8);
			{primary_gate_out, soft_start_active, pwm_adj_normal_bit, other_adjust_active} = r;
			e = (k < 40) && (r == 4'h8);
			tick(1);
			chk("rect", 16'(rectifier_gate_out), 16'(e));
		end
		ccr_host_i.wr(8'h06, 16'h0000);
		stored_address = 8'h20;
		tick(3);
		for (k = 0; k < 7; k++) begin
			chk("strap_req", 16'(strap_sample_req), 16'h0001);
			strap_sample_done = 1'b1;
			tick(1);
			strap_sample_done = 1'b0;
			tick(1);
		end
		chk("strap_end", 16'(strap_sample_req), 16'h0000);
		ccr_host_i.wr(8'h06, 16'h0100);
		tick(2);
		chk("strap_keep", 16'(strap_sample_req), 16'h0001);
		ccr_host_i.wr(8'h06, 16'h0009);
		soft_start_active = 1'b1;
		for (k = 0; k < 4; k++) begin
			measured_input_voltage = k ? 16'($urandom_range(0, 511)) : 16'h0100;
			measured_output_voltage = k ? 16'($urandom_range(0, 511)) : 16'h0100;
			tick(2);
			chk("start", 16'(start_permit), 16'(measured_input_voltage > 16'h0100));
			chk("hold", 16'(hold_min_ontime), 16'(measured_output_voltage <= 16'h0100));
		end
		for (k = 0; k < 2; k++) begin
			ccr_host_i.wr(8'h06, k ? 16'h0000 : 16'h0002);
			tick(SLOW);
			for (n = 0; n < 3000 && delay_count_tick !== 1'b1; n++)
				tick(1);
			lim(n);
			tick(1);
			for (n = 1; n < 3000 && delay_count_tick !== 1'b1; n++)
				tick(1);
			lim(n);
			chk("dly_tick", 16'(n), 16'(k ? FAST : SLOW));
		end
		for (k = 1; k < 4; k++) begin
			ccr_host_i.wr(8'h06, 16'(k << 4));
			tick(2);
			// two-cycle low on the data line must not pass the filter
			sda_pin = 1'b0;
			tick(2);
			sda_pin = 1'b1;
			e = 1'b1;
			for (n = 0; n < 8; n++) begin
				tick(1);
				e = e && (sda_filtered === 1'b1);
			end
			chk("glitch", 16'(e), 16'h0001);
			{scl_pin, sda_pin} = 2'h0;
			for (n = 0; n < 3000 && scl_filtered !== 1'b0; n++)
				tick(1);
			chk("filt", 16'(n), 16'(filt_cyc(k)));
			chk("filt_sda", 16'(sda_filtered), 16'h0000);
			{scl_pin, sda_pin} = 2'h3;
			tick(20);
		end
		conclude();
	end
endmodule
